//--- src/dsv_debug_dispatch.sv
// debug event dispatcher: halt, monitor exception or hard fault escalation,
// halting and monitor stepping, vector catch, apb register access
// assumes core events on mclk; restart request arrives asynchronously
`timescale 1ns/10ps
`include "dsv_map.svh"

module dsv_debug_dispatch
  import dsv_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external restart request pin
  input wire logic restart_req_pin,
  // processor core
  input wire dsv_core_evt_t core_evt,
  output dsv_core_ctl_t core_ctl
);

  // ****************************************************
  // decode
  // ****************************************************
  function automatic logic [1:0] dsv_decode(input logic [11:0] a);
    logic [1:0] r;
    r = 2'd3;
    if (a == `DSV_OFS_HALT_CTRL) r = 2'd0;
    if (a == `DSV_OFS_MON_CTRL) r = 2'd1;
    if (a == `DSV_OFS_FAULT_STAT) r = 2'd2;
    return r;
  endfunction : dsv_decode

  dsv_state_t state_reg;
  logic debug_en_reg;
  logic halt_req_reg;
  logic step_en_reg;
  logic mask_en_reg;
  logic step_lat_reg;
  logic mask_lat_reg;
  logic [31:0] mon_ctrl_reg;
  logic [2:0] fault_stat_reg;
  logic monitor_step_enable_busy_reg;
  logic restart_meta_reg;
  logic restart_sync_reg;
  logic restart_prev_reg;

  logic acc;
  logic wr;
  logic [1:0] sel;
  logic restart_pulse;
  logic breakpoint_event_flag_evt;
  logic mon_prio_ok;
  logic mon_active;
  logic halt_wr_ok;
  logic halt_cmd;
  logic leave_cmd;
  logic leave_by_wr;
  logic leave_step;
  logic leave_mask;
  logic breakpoint_event_flag_halt;
  logic breakpoint_event_flag_mon;
  logic breakpoint_event_flag_fault;
  logic vcatch;
  logic step_done;
  logic monitor_step_enable_done;
  logic [2:0] fs_set;
  logic [2:0] fs_clr;

  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign sel = dsv_decode(paddr);

  // ****************************************************
  // restart pin synchroniser
  // ****************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      restart_meta_reg <= 1'b0;
      restart_sync_reg <= 1'b0;
      restart_prev_reg <= 1'b0;
    end else begin
      restart_meta_reg <= restart_req_pin;
      restart_sync_reg <= restart_meta_reg;
      restart_prev_reg <= restart_sync_reg;
    end
  end
  assign restart_pulse = restart_sync_reg && !restart_prev_reg;

  // ****************************************************
  // event dispatch
  // ****************************************************
  assign breakpoint_event_flag_evt = core_evt.breakpoint_event_flag_instr || core_evt.breakpoint_event_flag_fpb;
  assign mon_prio_ok = core_evt.mon_prio < core_evt.exec_prio;
  assign breakpoint_event_flag_halt = breakpoint_event_flag_evt && debug_en_reg && state_reg != DSV_HALT;
  // no monitor escape inside nmi or hard fault handler
  assign breakpoint_event_flag_mon = breakpoint_event_flag_evt && !debug_en_reg && mon_ctrl_reg[`DSV_MC_MONITOR_ENABLE] && mon_prio_ok
    && !core_evt.in_nmi_hf;
  assign breakpoint_event_flag_fault = breakpoint_event_flag_evt && !debug_en_reg && !breakpoint_event_flag_mon;
  assign vcatch = debug_en_reg && core_evt.exc_entry && core_evt.fault_stat
    && |(core_evt.catch_sel & {mon_ctrl_reg[10:4], 3'b000, mon_ctrl_reg[0]})
    && state_reg != DSV_HALT;
  // encoding applies only when enabled and the write keeps debug enabled
  assign halt_wr_ok = wr && sel == 2'd0 && debug_en_reg && pwdata[`DSV_HC_DEBUG_EN];
  assign halt_cmd = halt_wr_ok && pwdata[`DSV_HC_HALT] && state_reg == DSV_RUN;

  // ****************************************************
  // leaving debug state
  // ****************************************************
  // halt clear or external restart
  assign leave_by_wr = state_reg == DSV_HALT && halt_wr_ok && !pwdata[`DSV_HC_HALT];
  assign leave_cmd = leave_by_wr || (state_reg == DSV_HALT && restart_pulse);
  // the leaving write itself chooses step and mask
  assign leave_step = leave_by_wr ? pwdata[`DSV_HC_STEP] : step_en_reg;
  assign leave_mask = leave_by_wr ? pwdata[`DSV_HC_MASK] : mask_en_reg;

  // first retired instruction or exception entry ends the step
  assign step_done = state_reg == DSV_STEP && (core_evt.instr_retire || core_evt.exc_entry);

  // ****************************************************
  // debug state machine
  // ****************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= DSV_RUN;
    end else begin
      unique case (state_reg)
        DSV_RUN: begin
          if (breakpoint_event_flag_halt || halt_cmd || vcatch) begin
            state_reg <= DSV_HALT;
          end
        end
        DSV_HALT: begin
          if (leave_cmd) begin
            state_reg <= leave_step ? DSV_STEP : DSV_RUN;
          end
        end
        DSV_STEP: begin
          // one instruction or exception, then halt
          if (step_done || breakpoint_event_flag_halt || !debug_en_reg) begin
            state_reg <= debug_en_reg ? DSV_HALT : DSV_RUN;
          end
        end
        default: begin
          state_reg <= DSV_RUN;
        end
      endcase
    end
  end

  // ****************************************************
  // halt control fields
  // ****************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      {mask_en_reg, step_en_reg, halt_req_reg, debug_en_reg} <= `DSV_RST_HALT_CTRL;
    end else begin
      if (wr && sel == 2'd0) begin
        debug_en_reg <= pwdata[`DSV_HC_DEBUG_EN];
      end
      if (halt_wr_ok && state_reg == DSV_HALT) begin
        halt_req_reg <= pwdata[`DSV_HC_HALT];
        step_en_reg <= pwdata[`DSV_HC_STEP];
        mask_en_reg <= pwdata[`DSV_HC_MASK];
      end else if (breakpoint_event_flag_halt || halt_cmd || vcatch || (step_done && debug_en_reg)) begin
        halt_req_reg <= 1'b1;
      end else if (leave_cmd) begin
        halt_req_reg <= 1'b0;
      end
    end
  end

  // ****************************************************
  // step and mask sampled at exit
  // ****************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      step_lat_reg <= 1'b0;
      mask_lat_reg <= 1'b0;
    end else if (leave_cmd) begin
      // sample step and mask at exit
      step_lat_reg <= leave_step;
      mask_lat_reg <= leave_mask;
    end else if (!debug_en_reg) begin
      step_lat_reg <= 1'b0;
      mask_lat_reg <= 1'b0;
    end
  end

  // ****************************************************
  // monitor control and monitor stepping
  // ****************************************************
  // monitor stepping conditions
  assign mon_active = !debug_en_reg && mon_ctrl_reg[`DSV_MC_MONITOR_ENABLE]
    && mon_ctrl_reg[`DSV_MC_MONITOR_STEP_ENABLE] && mon_prio_ok;
  // one instruction or one entry per step
  assign monitor_step_enable_done = monitor_step_enable_busy_reg && (core_evt.instr_retire || core_evt.exc_entry);

  always_ff @(posedge mclk) begin
    if (srst) begin
      monitor_step_enable_busy_reg <= 1'b0;
    end else if (monitor_step_enable_done) begin
      monitor_step_enable_busy_reg <= 1'b0;
    end else if (core_evt.exc_return && mon_active) begin
      // each monitor return starts a new step
      monitor_step_enable_busy_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      mon_ctrl_reg <= `DSV_RST_MON_CTRL;
    end else begin
      if (wr && sel == 2'd1) begin
        mon_ctrl_reg <= pwdata & (`DSV_MC_CATCH_MASK | (32'h7 << `DSV_MC_MONITOR_ENABLE));
      end
      if (core_evt.mon_taken) begin
        mon_ctrl_reg[`DSV_MC_MONITOR_PENDING] <= 1'b0;
      end
      // pend monitor when priority still low
      // pend as software would, set wins
      if ((monitor_step_enable_done && mon_prio_ok) || breakpoint_event_flag_mon) begin
        mon_ctrl_reg[`DSV_MC_MONITOR_PENDING] <= 1'b1;
      end
    end
  end

  // ****************************************************
  // debug fault status flags
  // ****************************************************
  // halt bit0, breakpoint bit1, catch bit3
  // halt requests and steps set halt flag
  assign fs_set[0] = halt_cmd || (step_done && debug_en_reg) || monitor_step_enable_done;
  assign fs_set[1] = breakpoint_event_flag_halt || breakpoint_event_flag_mon || breakpoint_event_flag_fault;
  assign fs_set[2] = vcatch;
  assign fs_clr = (wr && sel == 2'd2)
    ? {pwdata[`DSV_FS_VCATCH], pwdata[`DSV_FS_BREAKPOINT_EVENT_FLAG], pwdata[`DSV_FS_HALT]} : 3'h0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      fault_stat_reg <= `DSV_RST_FAULT_STAT;
    end else begin
      // set on taken event, write one clears
      fault_stat_reg <= (fault_stat_reg & ~fs_clr) | fs_set;
    end
  end

  // ****************************************************
  // core controls
  // ****************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      core_ctl <= '0;
    end else begin
      core_ctl.halted <= state_reg == DSV_HALT;
      // breakpoint in nmi or hard fault locks up
      core_ctl.hard_fault <= breakpoint_event_flag_fault && !core_evt.in_nmi_hf;
      if (breakpoint_event_flag_fault && core_evt.in_nmi_hf) begin
        core_ctl.lockup <= 1'b1;
      end
      core_ctl.monitor_pending <= mon_ctrl_reg[`DSV_MC_MONITOR_PENDING];
      core_ctl.irq_mask <= debug_en_reg && mask_lat_reg && state_reg != DSV_HALT;
      // halting step active only in the step state
      core_ctl.stepping <= debug_en_reg && step_lat_reg && state_reg == DSV_STEP;
    end
  end

  // ****************************************************
  // apb slave
  // ****************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= sel == 2'd3;
      prdata <= 32'h0000_0000;
      unique case (sel)
        2'd0: begin
          prdata[`DSV_HC_DEBUG_EN] <= debug_en_reg;
          prdata[`DSV_HC_HALT] <= debug_en_reg && halt_req_reg;
          prdata[`DSV_HC_STEP] <= debug_en_reg && step_en_reg;
          prdata[`DSV_HC_MASK] <= debug_en_reg && mask_en_reg;
          prdata[`DSV_HC_S_HALT] <= state_reg == DSV_HALT;
        end
        2'd1: begin
          prdata <= mon_ctrl_reg;
        end
        2'd2: begin
          prdata[`DSV_FS_HALT] <= fault_stat_reg[0];
          prdata[`DSV_FS_BREAKPOINT_EVENT_FLAG] <= fault_stat_reg[1];
          prdata[`DSV_FS_VCATCH] <= fault_stat_reg[2];
        end
        2'd3: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : dsv_debug_dispatch

//--- src/dsv_map.svh
// offsets, field positions and reset values of the debug dispatcher
// assumes inclusion by the top module, the checker and the bench only
`ifndef DSV_MAP_SVH
`define DSV_MAP_SVH

// ****************************************************
// register offsets (byte addresses on apb)
// ****************************************************
`define DSV_OFS_HALT_CTRL 12'h000
`define DSV_OFS_MON_CTRL 12'h00c
`define DSV_OFS_FAULT_STAT 12'h010

// ****************************************************
// halt_ctrl_status_reg fields
// ****************************************************
`define DSV_HC_DEBUG_EN 0
`define DSV_HC_HALT 1
`define DSV_HC_STEP 2
`define DSV_HC_MASK 3
`define DSV_HC_S_HALT 17

// ****************************************************
// exc_monitor_ctrl_reg fields
// ****************************************************
`define DSV_MC_CATCH_MASK 32'h0000_07f1
`define DSV_MC_MONITOR_ENABLE 16
`define DSV_MC_MONITOR_PENDING 17
`define DSV_MC_MONITOR_STEP_ENABLE 18

// ****************************************************
// debug_fault_status_reg fields
// ****************************************************
`define DSV_FS_HALT 0
`define DSV_FS_BREAKPOINT_EVENT_FLAG 1
`define DSV_FS_VCATCH 3

// ****************************************************
// reset values
// ****************************************************
`define DSV_RST_HALT_CTRL 4'h0
`define DSV_RST_MON_CTRL 32'h0000_0000
`define DSV_RST_FAULT_STAT 3'h0

`endif

//--- src/dsv_pkg.sv
// types shared by the debug event dispatcher
// assumes dsv_map.svh is on the include path
package dsv_pkg;

  // ****************************************************
  // debug state machine
  // ****************************************************
  typedef enum logic [1:0] {
    DSV_RUN = 2'b00,
    DSV_HALT = 2'b01,
    DSV_STEP = 2'b10
  } dsv_state_t;

  // ****************************************************
  // events from the processor core (same clock)
  // ****************************************************
  typedef struct packed {
    logic breakpoint_event_flag_instr;
    logic breakpoint_event_flag_fpb;
    logic in_nmi_hf;
    logic instr_retire;
    logic exc_entry;
    logic exc_return;
    logic mon_taken;
    logic fault_stat;
    logic [10:0] catch_sel;
    logic [7:0] exec_prio;
    logic [7:0] mon_prio;
  } dsv_core_evt_t;

  // ****************************************************
  // controls to the processor core
  // ****************************************************
  typedef struct packed {
    logic halted;
    logic hard_fault;
    logic lockup;
    logic monitor_pending;
    logic irq_mask;
    logic stepping;
  } dsv_core_ctl_t;

endpackage : dsv_pkg

//--- tb/dsv_dispatch_checker.sv
// port assertions for the debug event dispatcher
// assumes binding into dsv_debug_dispatch, one mclk domain
`timescale 1ns/10ps
`include "dsv_map.svh"
module dsv_dispatch_checker
  import dsv_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core side
  input wire logic restart_req_pin,
  input wire dsv_core_evt_t core_evt,
  input wire dsv_core_ctl_t core_ctl
);
  logic den_reg;
  logic [31:0] mc_reg;
  logic wr_ok;
  logic breakpoint_event_flag;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign breakpoint_event_flag = core_evt.breakpoint_event_flag_instr || core_evt.breakpoint_event_flag_fpb;
  // ****************************
  // shadow of the enables
  // ****************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      den_reg <= 1'b0;
    end else if (wr_ok && paddr == `DSV_OFS_HALT_CTRL) begin
      den_reg <= pwdata[`DSV_HC_DEBUG_EN];
    end
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      mc_reg <= 32'h0;
    end else if (wr_ok && paddr == `DSV_OFS_MON_CTRL) begin
      mc_reg <= pwdata;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence brk_off_s;
    breakpoint_event_flag && !den_reg && !mc_reg[`DSV_MC_MONITOR_ENABLE];
  endsequence
  chk_pready_next: assert property (setup_s |=> pready && penable)
    else $error("no answer after setup");
  chk_err_map: assert property (setup_s |=> pslverr != ($past(paddr) inside
    {`DSV_OFS_HALT_CTRL, `DSV_OFS_MON_CTRL, `DSV_OFS_FAULT_STAT}))
    else $error("error flag wrong for address");
  chk_breakpoint_event_flag_fault: assert property (
    brk_off_s ##0 !core_evt.in_nmi_hf |-> ##[1:2] core_ctl.hard_fault)
    else $error("breakpoint not escalated");
  chk_breakpoint_event_flag_lockup: assert property (
    breakpoint_event_flag && !den_reg && core_evt.in_nmi_hf |-> ##[1:2] core_ctl.lockup)
    else $error("no lockup in handler");
  chk_lockup_held: assert property (core_ctl.lockup |=> core_ctl.lockup)
    else $error("lockup released");
  chk_breakpoint_event_flag_halt: assert property (
    breakpoint_event_flag && den_reg && !core_ctl.halted |-> ##[1:2] core_ctl.halted)
    else $error("breakpoint did not halt");
  chk_monitor_pending: assert property (
    breakpoint_event_flag && !den_reg && mc_reg[`DSV_MC_MONITOR_ENABLE] && !core_evt.in_nmi_hf
    && core_evt.mon_prio < core_evt.exec_prio |-> ##[1:2] core_ctl.monitor_pending)
    else $error("monitor not pended");
  chk_step_end: assert property (
    core_ctl.stepping && (core_evt.instr_retire || core_evt.exc_entry)
    |-> ##[1:2] (core_ctl.halted && !core_ctl.stepping))
    else $error("step did not end in halt");
  chk_mask_held: assert property (
    core_ctl.stepping && $past(core_ctl.stepping) |-> $stable(core_ctl.irq_mask))
    else $error("mask changed in step");
  chk_vcatch_halt: assert property (
    den_reg && core_evt.exc_entry && core_evt.fault_stat
    && |(core_evt.catch_sel & mc_reg[10:0] & 11'h7f1) |-> ##[1:2] core_ctl.halted)
    else $error("vector catch missed");
endmodule : dsv_dispatch_checker

bind dsv_debug_dispatch dsv_dispatch_checker dsv_dispatch_checker_i (
  .mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .restart_req_pin(restart_req_pin), .core_evt(core_evt),
  .core_ctl(core_ctl));

//--- tb/dsv_dbg_host.sv
// apb master model of the external debugger
// assumes an apb slave on mclk that answers with pready
`timescale 1ns/10ps
module dsv_dbg_host (
  // clock
  input wire logic mclk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // slave answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // one transfer held until pready, released bus shows inverted values
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : dsv_dbg_host

//--- tb/dsv_debug_dispatch_tb_top.sv
// self-checking bench for the debug event dispatcher
// assumes dsv_map.svh on the include path and the bound checker
`timescale 1ns/10ps
`include "dsv_map.svh"
module dsv_debug_dispatch_tb_top
  import dsv_pkg::*;
;
  localparam logic [11:0] HC = `DSV_OFS_HALT_CTRL;
  localparam logic [11:0] MC = `DSV_OFS_MON_CTRL;
  localparam logic [11:0] FS = `DSV_OFS_FAULT_STAT;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, rerr, restart_req_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  dsv_core_evt_t core_evt, lv, e;
  dsv_core_ctl_t core_ctl;
  int num_errors, n_compared, hf_seen, k;

  dsv_debug_dispatch dsv_debug_dispatch_i (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .restart_req_pin(restart_req_pin), .core_evt(core_evt), .core_ctl(core_ctl));
  dsv_dbg_host dsv_dbg_host_i (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (core_ctl.hard_fault === 1'b1) hf_seen++;

  task automatic chk_reg(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask : chk_reg
  task automatic chk_ctl(input string nm, input logic x, input logic g);
    chk_reg(nm, {31'h0, x}, {31'h0, g});
  endtask : chk_ctl
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    dsv_dbg_host_i.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string nm);
    dsv_dbg_host_i.xfer(1'b0, a, 32'h0, rdat, rerr);
    chk_reg(nm, x, rdat);
  endtask : rd
  task automatic pulse(input dsv_core_evt_t ev);
    @(posedge mclk);
    core_evt <= ev;
    @(posedge mclk);
    core_evt <= lv;
    idle(4);
  endtask : pulse
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  initial begin
    idle(20000);
    num_errors++;
    give_verdict();
  end

  // ****************************
  // test sequence
  // ****************************
  initial begin
    srst = 1'b1;
    restart_req_pin = 1'b0;
    lv = '0;
    lv.exec_prio = 8'h80;
    lv.mon_prio = 8'h40;
    core_evt = lv;
    void'($urandom(32'h0dd6));
    idle(20);
    srst <= 1'b0;
    rd(HC, 32'h0, "halt ctrl");
    rd(FS, 32'h0, "fault status");
    rd(12'h004, 32'h0, "unmapped read");
    chk_ctl("unmapped error", 1'b1, rerr);
    $display("test reset done");
    e = lv;
    if ($urandom % 2) e.breakpoint_event_flag_fpb = 1'b1; else e.breakpoint_event_flag_instr = 1'b1;
    pulse(e);
    chk_ctl("hard fault", 1'b1, hf_seen == 1);
    rd(FS, 32'h2, "breakpoint flag");
    wr(FS, 32'h2);
    rd(FS, 32'h0, "cleared flag");
    $display("test escalation done");
    wr(MC, 32'h0001_0000);
    pulse(e);
    chk_ctl("monitor pending", 1'b1, core_ctl.monitor_pending);
    e = lv;
    e.mon_taken = 1'b1;
    pulse(e);
    chk_ctl("pending taken", 1'b0, core_ctl.monitor_pending);
    lv.mon_prio = 8'hc0;
    e = lv;
    e.breakpoint_event_flag_instr = 1'b1;
    pulse(e);
    chk_ctl("low monitor fault", 1'b1, hf_seen == 2);
    lv.mon_prio = 8'h40;
    wr(FS, 32'hb);
    wr(MC, 32'h0005_0000);
    e = lv;
    e.exc_return = 1'b1;
    pulse(e);
    e = lv;
    e.instr_retire = 1'b1;
    pulse(e);
    rd(MC, 32'h0007_0000, "monitor step");
    rd(FS, 32'h1, "monitor step flag");
    $display("test monitor done");
    wr(MC, 32'h0);
    wr(FS, 32'hb);
    wr(HC, 32'h1);
    wr(HC, 32'h3);
    idle(2);
    chk_ctl("halted", 1'b1, core_ctl.halted);
    rd(HC, 32'h0002_0003, "halt status");
    rd(FS, 32'h1, "halt flag");
    wr(FS, 32'h1);
    wr(HC, 32'hf);
    wr(HC, 32'hd);
    idle(3);
    chk_ctl("stepping", 1'b1, core_ctl.stepping);
    chk_ctl("step mask", 1'b1, core_ctl.irq_mask);
    pulse(e);
    chk_ctl("step halted", 1'b1, core_ctl.halted);
    rd(FS, 32'h1, "step flag");
    wr(HC, 32'h3);
    wr(HC, 32'h5);
    idle(3);
    chk_ctl("one write step", 1'b1, core_ctl.stepping);
    chk_ctl("step unmasked", 1'b0, core_ctl.irq_mask);
    pulse(e);
    chk_ctl("step halted again", 1'b1, core_ctl.halted);
    wr(HC, 32'h3);
    @(posedge mclk);
    restart_req_pin <= 1'b1;
    idle(3);
    restart_req_pin <= 1'b0;
    idle(6);
    chk_ctl("restarted", 1'b0, core_ctl.halted);
    wr(FS, 32'hb);
    e = lv;
    e.breakpoint_event_flag_fpb = 1'b1;
    pulse(e);
    chk_ctl("breakpoint_event_flag halted", 1'b1, core_ctl.halted);
    rd(FS, 32'h2, "breakpoint_event_flag halt flag");
    wr(FS, 32'hb);
    wr(HC, 32'h1);
    k = $urandom % 8;
    k = (k == 0) ? 0 : k + 3;
    wr(MC, 32'h1 << k);
    e = lv;
    e.exc_entry = 1'b1;
    e.fault_stat = 1'b1;
    e.catch_sel = 11'h1 << k;
    pulse(e);
    chk_ctl("catch halted", 1'b1, core_ctl.halted);
    rd(FS, 32'h8, "catch flag");
    wr(HC, 32'h1);
    wr(HC, 32'h0);
    wr(HC, 32'he);
    idle(3);
    chk_ctl("enable off run", 1'b0, core_ctl.halted);
    rd(HC, 32'h0, "ignored fields");
    $display("test halting done");
    wr(MC, 32'h0001_0000);
    lv.in_nmi_hf = 1'b1;
    e = lv;
    e.breakpoint_event_flag_instr = 1'b1;
    pulse(e);
    chk_ctl("lockup", 1'b1, core_ctl.lockup);
    $display("test lockup done");
    give_verdict();
  end
endmodule : dsv_debug_dispatch_tb_top
